/* File: logic/lefc_params.svh */
`ifndef LEFC_PARAMS_SVH
`define LEFC_PARAMS_SVH

// Clock rate, 5 ns period.
`define LEFC_CLK_HZ 200000000
// Switch debounce time in ms and its cycle count.
`define LEFC_DEBOUNCE_MS 37
`define LEFC_DEB_CYC (`LEFC_DEBOUNCE_MS * (`LEFC_CLK_HZ / 1000))
// Internal fade PWM rate in Hz; one period is cut into 4096 phase slots.
`define LEFC_PWM_HZ 220
`define LEFC_PWM_PHASES 4096
`define LEFC_PWM_SLOT_CYC (`LEFC_CLK_HZ / `LEFC_PWM_HZ / `LEFC_PWM_PHASES)
// Ramp time per kilohm of the time set value: 2.5 us.
`define LEFC_TSET_NS_PER_KOHM 2500
`define LEFC_TSET_CYC_PER_KOHM (`LEFC_TSET_NS_PER_KOHM / 5)
// Shorted time set: whole transition in about 70 us.
`define LEFC_INSTANT_US 70
`define LEFC_INSTANT_STEP_CYC ((`LEFC_INSTANT_US * 200 + 62) / 63)
// Fade steps and full duty.
`define LEFC_STEP_MAX 6'h3f
`define LEFC_DUTY_FULL 13'h1000
// Reset values.
`define LEFC_RST_STEP 6'h00
`define LEFC_RST_ON 1'b0

`endif

/* File: logic/lefc_pkg.sv */
package lefc_pkg;

   typedef enum logic {
      LEFC_MODE_LEVEL,
      LEFC_MODE_PULSE
   } lefc_mode_e;

   typedef struct packed {
      logic on;
      logic ramping;
      logic [5:0] step;
   } lefc_lamp_s;

endpackage

/* File: logic/lefc_top.sv */
//
// Function
// - Strap picks pulse toggle mode when high, level mode when low.
// - Pulse mode: debounced low pulse toggles channel, fading up or down.
// - Level mode: debounced rise fades up when off, stays on otherwise.
// - Level mode: debounced fall fades down when on, stays off otherwise.
// - Each switch is debounced about 37 ms on both edges.
// - After reset both lamps are off with toggle latches cleared.
// - Fade up and fade down each use their own programmed ramp time.
// - Fades run as 63 gamma corrected PWM duty steps.
// - A new toggle mid fade turns the ramp from the current step.
// - Each lamp has its own latch, debouncer and sequencer.
// - Backlight follows its enable with no fade, within a few cycles.
// - Shared PWM input triggering is handled outside this block.
// - A shorted ramp time runs the fade at the instant rate, finishing in about 70 us.
// - Fade steps are made by an internal PWM of about 220 Hz.
//
`timescale 1ns/100ps
`default_nettype none
`include "lefc_params.svh"

module lefc_top #(
   parameter int unsigned DEB_CYC = `LEFC_DEB_CYC,
   parameter int unsigned TSET_CYC_PER_KOHM = `LEFC_TSET_CYC_PER_KOHM,
   parameter int unsigned TSET_W = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] channel_switch_input,
   input wire logic backlight_enable_input,
   input wire logic switch_style_select,
   input wire logic [TSET_W-1:0] ramp_up_time_set,
   input wire logic [TSET_W-1:0] ramp_down_time_set,
   output logic [1:0] lamp_current_output,
   output logic backlight_current_output,
   output lefc_pkg::lefc_lamp_s [1:0] lamp_status
);

   ////////////////////////////////////////////////////////////////////////////

   localparam logic [22:0] DEB_LAST = 23'(DEB_CYC - 1);
   localparam logic [7:0] SLOT_LAST = 8'(`LEFC_PWM_SLOT_CYC - 1);
   localparam logic [19:0] INSTANT_CYC = 20'(`LEFC_INSTANT_STEP_CYC);

   // Gamma curve: square law, with the top step forced to full duty.
   function automatic logic [12:0] gamma_duty(input logic [5:0] s);
      logic [12:0] sq;
      sq = 13'({7'h00, s} * {7'h00, s});
      gamma_duty = (s == `LEFC_STEP_MAX) ? `LEFC_DUTY_FULL : sq;
   endfunction

   // Per step dwell; a shorted setting falls back to the instant rate.
   function automatic logic [19:0] dwell_cycles(input logic [TSET_W-1:0] set);
      logic [31:0] full;
      full = 32'(set) * 32'(TSET_CYC_PER_KOHM) / 32'd63;
      dwell_cycles = (set == '0) ? INSTANT_CYC : 20'(full);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   logic [1:0] sw_meta_q;
   logic [1:0] sw_sync_q;
   logic mode_meta_q;
   logic mode_sync_q;
   logic bl_meta_q;
   logic bl_sync_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sw_meta_q <= 2'h0;
         sw_sync_q <= 2'h0;
         mode_meta_q <= 1'b0;
         mode_sync_q <= 1'b0;
         bl_meta_q <= 1'b0;
         bl_sync_q <= 1'b0;
      end else begin
         sw_meta_q <= channel_switch_input;
         sw_sync_q <= sw_meta_q;
         mode_meta_q <= switch_style_select;
         mode_sync_q <= mode_meta_q;
         bl_meta_q <= backlight_enable_input;
         bl_sync_q <= bl_meta_q;
      end
   end

   wire lefc_pkg::lefc_mode_e mode = mode_sync_q ? lefc_pkg::LEFC_MODE_PULSE
                                                 : lefc_pkg::LEFC_MODE_LEVEL;

   ////////////////////////////////////////////////////////////////////////////
   // Shared fade PWM timebase.

   logic [7:0] slot_cnt_q;
   logic [11:0] phase_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         slot_cnt_q <= 8'h00;
         phase_q <= 12'h000;
      end else if (slot_cnt_q == SLOT_LAST) begin
         slot_cnt_q <= 8'h00;
         phase_q <= phase_q + 12'h001;
      end else begin
         slot_cnt_q <= slot_cnt_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per lamp debounce, toggle latch and fade sequencer.

   logic [22:0] deb_cnt_q [2];
   logic [1:0] deb_q;
   logic [1:0] on_q;
   logic [5:0] step_q [2];
   logic [19:0] dwell_q [2];
   logic [1:0] lamp_out_q;
   logic [1:0] ramp_q;

   wire [19:0] up_dwell = dwell_cycles(ramp_up_time_set);
   wire [19:0] dn_dwell = dwell_cycles(ramp_down_time_set);

   logic [1:0] differ;
   logic [1:0] accept;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] on_d;
   logic [1:0] at_target;
   logic [1:0] going_up;
   logic [1:0] step_due;
   logic [19:0] dwell_lim [2];
   logic [5:0] step_d [2];
   logic [1:0] ramp_d;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         differ[c] = sw_sync_q[c] != deb_q[c];
         accept[c] = differ[c] && (deb_cnt_q[c] == DEB_LAST);
         rise[c] = accept[c] && sw_sync_q[c];
         fall[c] = accept[c] && !sw_sync_q[c];
         on_d[c] = on_q[c];
         if (mode == lefc_pkg::LEFC_MODE_PULSE) begin
            if (fall[c]) begin
               on_d[c] = !on_q[c];
            end
         end else if (rise[c]) begin
            on_d[c] = 1'b1;
         end else if (fall[c]) begin
            on_d[c] = 1'b0;
         end
         at_target[c] = on_q[c] ? (step_q[c] == `LEFC_STEP_MAX)
                                : (step_q[c] == 6'h00);
         going_up[c] = on_q[c] && !at_target[c];
         dwell_lim[c] = going_up[c] ? up_dwell : dn_dwell;
         step_due[c] = !at_target[c] && (dwell_q[c] + 20'h00001 >= dwell_lim[c]);
         step_d[c] = step_q[c];
         if (step_due[c]) begin
            step_d[c] = going_up[c] ? step_q[c] + 6'h01 : step_q[c] - 6'h01;
         end
         // Ramping is judged on the next state so that the status bit is a register.
         ramp_d[c] = on_d[c] ? (step_d[c] != `LEFC_STEP_MAX) : (step_d[c] != 6'h00);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         deb_q <= 2'h0;
         on_q <= {2{`LEFC_RST_ON}};
         lamp_out_q <= 2'h0;
         ramp_q <= 2'h0;
         for (int c = 0; c < 2; c++) begin
            deb_cnt_q[c] <= 23'h000000;
            step_q[c] <= `LEFC_RST_STEP;
            dwell_q[c] <= 20'h00000;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            // Any return to the accepted level restarts the count.
            if (!differ[c] || accept[c]) begin
               deb_cnt_q[c] <= 23'h000000;
            end else begin
               deb_cnt_q[c] <= deb_cnt_q[c] + 23'h000001;
            end
            if (accept[c]) begin
               deb_q[c] <= sw_sync_q[c];
            end
            on_q[c] <= on_d[c];
            // Dwell keeps running across a reversal so the turn is seamless.
            if (step_due[c] || at_target[c]) begin
               dwell_q[c] <= 20'h00000;
            end else begin
               dwell_q[c] <= dwell_q[c] + 20'h00001;
            end
            step_q[c] <= step_d[c];
            ramp_q[c] <= ramp_d[c];
            lamp_out_q[c] <= {1'b0, phase_q} < gamma_duty(step_q[c]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Backlight and status outputs.

   logic bl_out_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bl_out_q <= 1'b0;
      end else begin
         bl_out_q <= bl_sync_q;
      end
   end

   assign lamp_current_output = lamp_out_q;
   assign backlight_current_output = bl_out_q;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         lamp_status[c].on = on_q[c];
         lamp_status[c].ramping = ramp_q[c];
         lamp_status[c].step = step_q[c];
      end
   end

endmodule
`default_nettype wire

/* File: verif/lefc_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module lefc_chk #(
   parameter int unsigned DEB_CYC = 20
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] channel_switch_input,
   input wire logic backlight_enable_input,
   input wire logic [1:0] lamp_current_output,
   input wire logic backlight_current_output,
   input wire lefc_pkg::lefc_lamp_s [1:0] lamp_status
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire logic [5:0] s0 = lamp_status[0].step;
   wire logic o0 = lamp_status[0].on;
   logic p_q;
   int unsigned st_q;
   // Counts how long lamp 0's pin has held still, to judge the debounce.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         p_q <= 1'b0;
         st_q <= 0;
      end else begin
         p_q <= channel_switch_input[0];
         st_q <= (channel_switch_input[0] != p_q) ? 0 : st_q + 1;
      end
   end
   AST_RST_OFF: assert property ($fell(reset) |-> lamp_status == '0 && lamp_current_output == '0)
      else $error("lamp not off after reset");
   AST_DEB: assert property ($changed(o0) |-> st_q >= DEB_CYC - 2)
      else $error("lamp toggled before debounce");
   AST_STEP1: assert property ($changed(s0) |-> s0 == $past(s0) + 6'h01 || s0 == $past(s0) - 6'h01)
      else $error("fade step jumped");
   AST_UP: assert property (o0 && $past(o0) |-> s0 >= $past(s0))
      else $error("step fell while on");
   AST_DN: assert property (!o0 && !$past(o0) |-> s0 <= $past(s0))
      else $error("step rose while off");
   AST_FULL: assert property ($past(s0) == 6'h3f |-> lamp_current_output[0])
      else $error("full step not always on");
   AST_ZERO: assert property ($past(s0) == 6'h00 |-> !lamp_current_output[0])
      else $error("zero step not off");
   AST_BL: assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3)
      |-> backlight_current_output == $past(backlight_enable_input, 3))
      else $error("backlight does not follow enable");
   cover property (s0 == 6'h3f);
   cover property ($rose(o0) && s0 != 6'h00);
   cover property ($rose(backlight_current_output));
endmodule
`default_nettype wire

/* File: verif/lefc_sw.sv */
`timescale 1ns/100ps
`default_nettype none
// Switch with contact bounce: five chattering cycles before each new level settles.
module lefc_sw (
   input wire logic clk,
   input wire logic lvl,
   output logic pin
);
   logic [2:0] b_q = 3'h0;
   initial pin = 1'b0;
   always @(negedge clk) begin
      if (b_q != 3'h0) begin
         b_q <= b_q - 3'h1;
         pin <= (b_q == 3'h1) ? lvl : ~pin;
      end else if (pin != lvl) begin
         b_q <= 3'h5;
         pin <= lvl;
      end
   end
endmodule
`default_nettype wire

/* File: verif/tb_lefc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lefc_params.svh"
module tb_lefc_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic bl = 1'b0;
   logic mode = 1'b1;
   logic [1:0] lvl = 2'h3;
   logic [9:0] up_set = 10'h002;
   logic [9:0] dn_set = 10'h004;
   wire logic [1:0] sw;
   wire logic [1:0] lamp;
   wire logic blo;
   lefc_pkg::lefc_lamp_s [1:0] st;
   int n_mismatch = 0;
   int n_compared = 0;
   initial forever #2.5 clk = ~clk;
   lefc_sw u_lefc_sw0 (.clk(clk), .lvl(lvl[0]), .pin(sw[0]));
   lefc_sw u_lefc_sw1 (.clk(clk), .lvl(lvl[1]), .pin(sw[1]));
   lefc_top #(.DEB_CYC(20), .TSET_CYC_PER_KOHM(63), .TSET_W(10)) u_lefc_top (
      .clk(clk), .reset(reset), .channel_switch_input(sw), .backlight_enable_input(bl),
      .switch_style_select(mode), .ramp_up_time_set(up_set), .ramp_down_time_set(dn_set),
      .lamp_current_output(lamp), .backlight_current_output(blo), .lamp_status(st));
   task automatic end_sim();
      if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Sets a switch level, then waits n cycles; callers pass an n below the debounce to make a glitch.
   task automatic setsw(input int c, input logic v, input int n);
      @(posedge clk);
      lvl[c] = v;
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_st(input int c, input logic [7:0] exp);
      int i;
      for (i = 0; i < 3000 && st[c] !== exp; i++) @(negedge clk);
      chk("status", st[c], exp);
      if (i == 3000) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   // Counts cycles from the latch change to the end of the fade.
   task automatic ramp_len(input int c, input logic [7:0] tgt, input logic [15:0] exp);
      int i;
      int n;
      for (i = 0; i < 100 && st[c].on !== tgt[7]; i++) @(negedge clk);
      for (n = 0; n < 20000 && st[c] !== tgt; n++) @(negedge clk);
      chk("ramp cycles", 16'(n), exp);
      if (i == 100 || n == 20000) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   task automatic t_reset();
      repeat (40) @(negedge clk);
      chk("status0", st[0], 8'h00);
      chk("status1", st[1], 8'h00);
      chk("lamp", {6'h00, lamp}, 8'h00);
   endtask
   task automatic t_backlight();
      bl = 1'b1;
      repeat (4) @(negedge clk);
      chk("blo", {7'h00, blo}, 8'h01);
      bl = 1'b0;
      repeat (4) @(negedge clk);
      chk("blo", {7'h00, blo}, 8'h00);
   endtask
   task automatic t_pulse();
      setsw(0, 1'b0, 40);
      setsw(0, 1'b1, 40);
      wait_st(0, 8'hbf);
      chk("status1", st[1], 8'h00);
      setsw(0, 1'b0, 12);
      setsw(0, 1'b1, 40);
      chk("glitch", st[0], 8'hbf);
      setsw(0, 1'b0, 40);
      setsw(0, 1'b1, 35);
      setsw(0, 1'b0, 35);
      chk("reverse", {6'h00, st[0][7:6]}, 8'h03);
      setsw(0, 1'b1, 35);
      wait_st(0, 8'hbf);
      setsw(0, 1'b0, 35);
      setsw(0, 1'b1, 35);
      wait_st(0, 8'h00);
   endtask
   task automatic t_level();
      mode = 1'b0;
      setsw(0, 1'b0, 35);
      setsw(1, 1'b0, 35);
      chk("status0", st[0], 8'h00);
      setsw(1, 1'b1, 35);
      wait_st(1, 8'hbf);
      chk("status0", st[0], 8'h00);
      setsw(1, 1'b0, 35);
      wait_st(1, 8'h00);
   endtask
   task automatic t_ramp();
      setsw(1, 1'b1, 0);
      ramp_len(1, 8'hbf, 16'd126);
      setsw(1, 1'b0, 0);
      ramp_len(1, 8'h00, 16'd252);
      up_set = 10'h000;
      setsw(1, 1'b1, 0);
      ramp_len(1, 8'hbf, 16'(63 * `LEFC_INSTANT_STEP_CYC));
   endtask
   task automatic t_midreset();
      reset = 1'b1;
      repeat (3) @(negedge clk);
      chk("reset lamp", {6'h00, lamp}, 8'h00);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      chk("reset status1", st[1], 8'h00);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_backlight();
      t_pulse();
      t_level();
      t_ramp();
      t_midreset();
      end_sim();
   end
endmodule
bind lefc_top lefc_chk #(.DEB_CYC(DEB_CYC)) u_lefc_chk (.clk, .reset, .channel_switch_input,
   .backlight_enable_input, .lamp_current_output, .backlight_current_output, .lamp_status);
`default_nettype wire
